//--- design/ckg_clock_ctrl.sv
//Contract
//- multiplied clock runs at four times the main oscillator rate.
//- multiplier-use bit picks main (0) or multiplied (1) high-speed clock; resets 0.
//- gear divides high-speed clock by 1, 2, 4 or 8; reset is by 1.
//- gear write takes effect after a short delay, not immediately.
//- prescaler clock is peripheral source divided by 1 to 32 per select field.
//- after reset the prescaler clock equals the undivided peripheral source.
//- system clock is geared clock when select is 0, low-speed when 1.
//- clock status shows actual system source, updated once switch completes.
//- reset leaves both oscillators on, multiplier off, gear undivided.
//- after reset high-speed, system and prescaler clocks equal main oscillator.
//- multiplier off after reset, runs only after software sets its enable.
//- core clocks follow system clock and stop in idle, sleep and stop.
//- tick timer reference is main oscillator divided by 32.
//- wake from stop or sleep starts warm-up; core clocks wait for it.
//- warm-up counts main cycles when select is 0, low-speed when 1.
//- warm-up length follows 3-bit time field per selected counting clock.
//- start bit launches warm-up; flag reads 1 while counting, 0 when done.
//- multiplier is disabled in stop and sleep modes.
//- clock output select: low-speed, half system, system, prescaler.
//- pin drives clock output only when direction and alternate bits are 1.
//- without low-speed clock, slow and sleep modes are unavailable.
`default_nettype none
module ckg_clock_ctrl (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // oscillator pins
   input wire logic main_osc_i,
   input wire logic low_osc_i,
   output logic main_osc_en_o,
   output logic low_osc_en_o,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // core low-power handshake
   input wire logic lp_enter_i,
   input wire logic [1:0] lp_mode_i,
   input wire logic wake_i,
   // port configuration for the shared pin
   input wire logic port_pin_dir_bit_i,
   input wire logic port_pin_alt_fn_bit_i,
   // clock ticks
   output logic high_speed_tick_o,
   output logic sys_tick_o,
   output logic prescaler_tick_o,
   output logic core_bus_tick_o,
   output logic core_free_tick_o,
   output logic tick_ref_tick_o,
   output logic warmup_running_flag_o,
   // clock output pin
   output logic clkout_pin_o,
   output logic clkout_pin_oe_o
);
   import ckg_pkg::*;

   // oscillator synchronisers
   logic [1:0] main_sync;
   logic [1:0] low_sync;
   logic main_prev;
   logic low_prev;
   logic main_tick;
   logic low_tick;
   // registers
   logic warmup_low_sel;
   logic [2:0] warmup_time;
   logic mult_enable;
   logic mult_use_sel;
   logic [2:0] gear_req;
   logic [2:0] gear_act;
   logic [2:0] gear_wait;
   logic [2:0] prescale_div_sel;
   logic periph_src_sel;
   logic [1:0] clkout_sel;
   logic sysclk_sel;
   logic sysclk_src_status;
   // warm-up
   logic [WU_W-1:0] wu_cnt;
   logic [WU_W-1:0] wu_len;
   logic wu_src_tick;
   logic wu_start;
   logic wu_done;
   // state and derived ticks
   ckg_state_t state;
   ckg_state_t next_state;
   logic deep_sleep;
   logic lp_active;
   logic mult_run;
   logic mult_tick;
   logic hs_tick;
   logic gear_tick;
   logic periph_tick;
   logic presc_div_tick;
   logic presc_tick;
   logic sys_tick;
   logic sys_half_tick;
   logic tick_ref;
   logic out_tick;
   logic [2:0] presc_log2;
   logic wr_osc;
   logic wr_cfg;
   logic wr_sel;
   logic wr_mult;

   // both oscillators pass two flops before any edge logic
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         main_sync <= 2'h0;
         low_sync <= 2'h0;
         main_prev <= 1'b0;
         low_prev <= 1'b0;
      end else begin
         main_sync <= {main_sync[0], main_osc_i};
         low_sync <= {low_sync[0], low_osc_i};
         main_prev <= main_sync[1];
         low_prev <= low_sync[1];
      end
   end

   // the stop mode masks the edges of both oscillators; their enables stay set
   assign deep_sleep = (state == CKG_STOP) || (state == CKG_SLEEP);
   assign main_tick = main_sync[1] && !main_prev && main_osc_en_o && state != CKG_STOP;
   assign low_tick = low_sync[1] && !low_prev && low_osc_en_o && state != CKG_STOP;
   assign lp_active = (state != CKG_RUN);

   assign wr_osc = wr_i && addr_i == OSC_CONTROL_REG_OFS;
   assign wr_cfg = wr_i && addr_i == SYS_CLOCK_CFG_REG_OFS;
   assign wr_sel = wr_i && addr_i == SYSCLK_SELECT_REG_OFS;
   assign wr_mult = wr_i && addr_i == MULT_SELECT_REG_OFS;

   // oscillator and warm-up control
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         main_osc_en_o <= 1'b1;
         low_osc_en_o <= 1'b1;
         mult_enable <= 1'b0;
         warmup_low_sel <= 1'b0;
         warmup_time <= 3'h0;
      end else if (wr_osc) begin
         main_osc_en_o <= wdata_i[MAIN_OSC_EN_BIT];
         low_osc_en_o <= wdata_i[LOW_OSC_EN_BIT];
         mult_enable <= wdata_i[MULT_ENABLE_BIT];
         warmup_low_sel <= wdata_i[WARMUP_CLK_SEL_BIT];
         warmup_time <= wdata_i[WARMUP_TIME_LSB +: 3];
      end
   end

   // clock configuration
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         gear_req <= GEAR_RESET;
         prescale_div_sel <= PRESCALE_RESET;
         periph_src_sel <= 1'b0;
         clkout_sel <= CLKOUT_LOW;
      end else if (wr_cfg) begin
         // reserved gear codes leave the gear where it was
         if (wdata_i[GEAR_LSB +: 3] <= GEAR_MAX_CODE) begin
            gear_req <= wdata_i[GEAR_LSB +: 3];
         end
         prescale_div_sel <= wdata_i[PRESCALE_LSB +: 3];
         periph_src_sel <= wdata_i[PERIPH_SRC_BIT];
         clkout_sel <= wdata_i[CLKOUT_SEL_LSB +: 2];
      end
   end

   // new gear waits out a short settling delay
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         gear_act <= GEAR_RESET;
         gear_wait <= 3'h0;
      end else if (wr_cfg) begin
         gear_wait <= 3'(GEAR_DELAY_CYC);
      end else if (gear_wait != 3'h0) begin
         gear_wait <= gear_wait - 3'h1;
         if (gear_wait == 3'h1) begin
            gear_act <= gear_req;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         mult_use_sel <= 1'b0;
      end else if (wr_mult) begin
         mult_use_sel <= wdata_i[MULT_USE_BIT];
      end
   end

   // selecting low speed needs the low-speed oscillator running
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         sysclk_sel <= 1'b0;
      end else if (wr_sel) begin
         sysclk_sel <= wdata_i[SYSCLK_SEL_BIT] && low_osc_en_o;
      end
   end

   // status flips only on an edge of the newly chosen clock
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         sysclk_src_status <= 1'b0;
      end else if (sysclk_sel != sysclk_src_status) begin
         if (sysclk_sel ? low_tick : gear_tick) begin
            sysclk_src_status <= sysclk_sel;
         end
      end
   end

   // low-power state
   always_comb begin
      next_state = state;
      case (state)
         CKG_RUN: begin
            if (lp_enter_i) begin
               case (lp_mode_i)
                  LP_IDLE: next_state = CKG_IDLE;
                  LP_STOP: next_state = CKG_STOP;
                  LP_SLEEP: next_state = low_osc_en_o ? CKG_SLEEP : CKG_RUN;
                  default: next_state = CKG_RUN;
               endcase
            end
         end
         CKG_IDLE: begin
            if (wake_i) begin
               next_state = CKG_RUN;
            end
         end
         CKG_SLEEP, CKG_STOP: begin
            if (wake_i) begin
               next_state = CKG_WARM;
            end
         end
         CKG_WARM: begin
            if (!warmup_running_flag_o) begin
               next_state = CKG_RUN;
            end
         end
         default: next_state = CKG_RUN;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state <= CKG_RUN;
      end else begin
         state <= next_state;
      end
   end

   // warm-up counter
   assign wu_start = (wr_osc && wdata_i[WARMUP_START_BIT]) ||
      (deep_sleep && wake_i);
   assign wu_src_tick = warmup_low_sel ? low_tick : main_tick;
   assign wu_len = ckg_wu_len(warmup_low_sel, warmup_time);
   assign wu_done = (wu_len == '0) || (wu_src_tick && wu_cnt == wu_len - WU_W'(1));

   // a start in the finishing cycle restarts the count
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         warmup_running_flag_o <= 1'b0;
         wu_cnt <= '0;
      end else if (wu_start) begin
         warmup_running_flag_o <= 1'b1;
         wu_cnt <= '0;
      end else if (warmup_running_flag_o) begin
         if (wu_done) begin
            warmup_running_flag_o <= 1'b0;
         end else if (wu_src_tick) begin
            wu_cnt <= wu_cnt + WU_W'(1);
         end
      end
   end

   // clock tree
   assign mult_run = mult_enable && !deep_sleep;
   assign hs_tick = mult_use_sel ? mult_tick : main_tick;
   assign sys_tick = sysclk_src_status ? low_tick : gear_tick;
   assign periph_tick = periph_src_sel ? hs_tick : gear_tick;
   assign presc_log2 = (prescale_div_sel > PRESCALE_MAX_CODE) ? 3'h0 : prescale_div_sel;
   assign presc_tick = (prescale_div_sel == 3'h0) ? periph_tick : presc_div_tick;

   ckg_mult4 u_mult (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .enable_i(mult_run),
      .main_tick_i(main_tick),
      .mult_tick_o(mult_tick),
      .locked_o()
   );

   ckg_tick_div u_gear (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .tick_i(hs_tick),
      .div_log2_i(gear_act),
      .tick_o(gear_tick)
   );

   ckg_tick_div u_presc (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .tick_i(periph_tick),
      .div_log2_i(presc_log2),
      .tick_o(presc_div_tick)
   );

   ckg_tick_div u_tick_ref (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .tick_i(main_tick),
      .div_log2_i(TICK_REF_LOG2),
      .tick_o(tick_ref)
   );

   ckg_tick_div u_sys_half (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .tick_i(sys_tick && !deep_sleep),
      .div_log2_i(HALF_LOG2),
      .tick_o(sys_half_tick)
   );

   // output ticks; divided paths carry one more cycle of latency
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         high_speed_tick_o <= 1'b0;
         sys_tick_o <= 1'b0;
         prescaler_tick_o <= 1'b0;
         core_bus_tick_o <= 1'b0;
         core_free_tick_o <= 1'b0;
         tick_ref_tick_o <= 1'b0;
      end else begin
         high_speed_tick_o <= hs_tick;
         sys_tick_o <= sys_tick;
         prescaler_tick_o <= presc_tick;
         core_bus_tick_o <= sys_tick && !lp_active;
         core_free_tick_o <= sys_tick && !lp_active;
         tick_ref_tick_o <= tick_ref;
      end
   end

   // clock output pin
   always_comb begin
      case (clkout_sel)
         CLKOUT_LOW: out_tick = low_tick;
         CLKOUT_SYS_HALF: out_tick = sys_half_tick;
         CLKOUT_SYS: out_tick = sys_tick && !deep_sleep;
         default: out_tick = presc_tick && !lp_active;
      endcase
   end

   // with no source edges the pin simply keeps its level
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         clkout_pin_o <= 1'b0;
         clkout_pin_oe_o <= 1'b0;
      end else begin
         if (out_tick) begin
            clkout_pin_o <= !clkout_pin_o;
         end
         clkout_pin_oe_o <= port_pin_dir_bit_i && port_pin_alt_fn_bit_i;
      end
   end

   // register read, one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         rdata_o <= 32'h0000_0000;
         case (addr_i)
            OSC_CONTROL_REG_OFS: begin
               rdata_o[WARMUP_FLAG_BIT] <= warmup_running_flag_o;
               rdata_o[WARMUP_CLK_SEL_BIT] <= warmup_low_sel;
               rdata_o[WARMUP_TIME_LSB +: 3] <= warmup_time;
               rdata_o[MULT_ENABLE_BIT] <= mult_enable;
               rdata_o[MAIN_OSC_EN_BIT] <= main_osc_en_o;
               rdata_o[LOW_OSC_EN_BIT] <= low_osc_en_o;
            end
            SYS_CLOCK_CFG_REG_OFS: begin
               rdata_o[GEAR_LSB +: 3] <= gear_req;
               rdata_o[PRESCALE_LSB +: 3] <= prescale_div_sel;
               rdata_o[PERIPH_SRC_BIT] <= periph_src_sel;
               rdata_o[CLKOUT_SEL_LSB +: 2] <= clkout_sel;
            end
            SYSCLK_SELECT_REG_OFS: begin
               rdata_o[SYSCLK_SEL_BIT] <= sysclk_sel;
               rdata_o[SYSCLK_STATUS_BIT] <= sysclk_src_status;
            end
            MULT_SELECT_REG_OFS: begin
               rdata_o[MULT_USE_BIT] <= mult_use_sel;
            end
            default: rdata_o <= 32'h0000_0000;
         endcase
      end
   end
endmodule : ckg_clock_ctrl
`default_nettype wire

//--- design/ckg_mult4.sv
`default_nettype none
module ckg_mult4 (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // control
   input wire logic enable_i,
   input wire logic main_tick_i,
   // multiplied clock ticks
   output logic mult_tick_o,
   output logic locked_o
);
   import ckg_pkg::*;

   logic [15:0] per_cnt;
   logic [15:0] period;
   logic [15:0] phase;
   logic [13:0] quarter;
   logic seen;

   assign quarter = period[15:2];

   // period measured in system cycles between main edges
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || !enable_i) begin
         per_cnt <= 16'h0000;
         period <= 16'h0000;
         seen <= 1'b0;
         locked_o <= 1'b0;
      end else if (main_tick_i) begin
         per_cnt <= 16'h0001;
         seen <= 1'b1;
         if (seen) begin
            period <= per_cnt;
            locked_o <= 1'b1;
         end
      end else if (per_cnt != 16'hFFFF) begin
         per_cnt <= per_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i || !enable_i) begin
         phase <= 16'h0000;
      end else if (main_tick_i) begin
         phase <= 16'h0001;
      end else if (phase != 16'hFFFF) begin
         phase <= phase + 16'h0001;
      end
   end

   // four evenly spaced edges per main period
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || !enable_i) begin
         mult_tick_o <= 1'b0;
      end else begin
         mult_tick_o <= locked_o && (main_tick_i || (quarter != 14'h0000 &&
            (phase == {2'h0, quarter} || phase == {1'b0, quarter, 1'b0} ||
             phase == 16'({2'h0, quarter} + {1'b0, quarter, 1'b0}))));
      end
   end
endmodule : ckg_mult4
`default_nettype wire

//--- design/ckg_pkg.sv
`default_nettype none
package ckg_pkg;
   // register byte offsets
   localparam logic [7:0] OSC_CONTROL_REG_OFS = 8'h00;
   localparam logic [7:0] SYS_CLOCK_CFG_REG_OFS = 8'h04;
   localparam logic [7:0] SYSCLK_SELECT_REG_OFS = 8'h08;
   localparam logic [7:0] MULT_SELECT_REG_OFS = 8'h0C;
   // osc_control_reg fields
   localparam int WARMUP_START_BIT = 0;
   localparam int WARMUP_FLAG_BIT = 1;
   localparam int WARMUP_CLK_SEL_BIT = 2;
   localparam int WARMUP_TIME_LSB = 4;
   localparam int MULT_ENABLE_BIT = 8;
   localparam int MAIN_OSC_EN_BIT = 9;
   localparam int LOW_OSC_EN_BIT = 10;
   // sys_clock_cfg_reg fields
   localparam int GEAR_LSB = 0;
   localparam int PRESCALE_LSB = 4;
   localparam int PERIPH_SRC_BIT = 8;
   localparam int CLKOUT_SEL_LSB = 12;
   // sysclk_select_reg and mult_select_reg fields
   localparam int SYSCLK_STATUS_BIT = 0;
   localparam int SYSCLK_SEL_BIT = 1;
   localparam int MULT_USE_BIT = 0;
   // reset values and highest legal codes
   localparam logic [2:0] GEAR_RESET = 3'h0;
   localparam logic [2:0] PRESCALE_RESET = 3'h0;
   localparam logic [2:0] GEAR_MAX_CODE = 3'h3;
   localparam logic [2:0] PRESCALE_MAX_CODE = 3'h5;
   // clkout source codes
   localparam logic [1:0] CLKOUT_LOW = 2'h0;
   localparam logic [1:0] CLKOUT_SYS_HALF = 2'h1;
   localparam logic [1:0] CLKOUT_SYS = 2'h2;
   localparam logic [1:0] CLKOUT_PRESCALE = 2'h3;
   // low-power request codes from the core
   localparam logic [1:0] LP_STOP = 2'h1;
   localparam logic [1:0] LP_SLEEP = 2'h2;
   localparam logic [1:0] LP_IDLE = 2'h3;
   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int GEAR_DELAY_NS = 32;
   localparam int GEAR_DELAY_CYC = (GEAR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] TICK_REF_LOG2 = 3'h5;
   localparam logic [2:0] HALF_LOG2 = 3'h1;
   localparam int WU_W = 19;

   typedef enum logic [2:0] {
      CKG_RUN,
      CKG_IDLE,
      CKG_SLEEP,
      CKG_STOP,
      CKG_WARM
   } ckg_state_t;

   // warm-up length in oscillator cycles
   function automatic logic [WU_W-1:0] ckg_wu_len(input logic low_sel, input logic [2:0] code);
      logic [WU_W-1:0] len;
      len = '0;
      if (!low_sel) begin
         if (code != 3'h0) begin
            len = WU_W'(1) << (9 + int'(code));
         end
      end else begin
         case (code)
            3'h0, 3'h1: len = WU_W'(1) << 6;
            3'h2: len = WU_W'(1) << 7;
            3'h3: len = WU_W'(1) << 8;
            3'h4: len = WU_W'(1) << 15;
            3'h5: len = WU_W'(1) << 16;
            3'h6: len = WU_W'(1) << 17;
            default: len = WU_W'(1) << 18;
         endcase
      end
      return len;
   endfunction : ckg_wu_len
endpackage : ckg_pkg
`default_nettype wire

//--- design/ckg_tick_div.sv
`default_nettype none
module ckg_tick_div (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // ticks
   input wire logic tick_i,
   input wire logic [2:0] div_log2_i,
   output logic tick_o
);
   import ckg_pkg::*;

   logic [4:0] cnt;
   logic [4:0] mask;

   assign mask = 5'((6'h01 << div_log2_i) - 6'h01);

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cnt <= 5'h00;
      end else if (tick_i) begin
         cnt <= cnt + 5'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= tick_i && ((cnt & mask) == mask);
      end
   end
endmodule : ckg_tick_div
`default_nettype wire

//--- sim/ckg_clock_ctrl_chk.sv
`default_nettype none
module ckg_clock_ctrl_chk
   import ckg_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   // core and pin side
   input wire logic lp_enter_i,
   input wire logic [1:0] lp_mode_i,
   input wire logic port_pin_dir_bit_i,
   input wire logic port_pin_alt_fn_bit_i,
   input wire logic sys_tick_o,
   input wire logic core_bus_tick_o,
   input wire logic core_free_tick_o,
   input wire logic tick_ref_tick_o,
   input wire logic warmup_running_flag_o,
   input wire logic clkout_pin_oe_o,
   input wire logic main_osc_en_o,
   input wire logic low_osc_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   reset_state_a: assert property (disable iff (1'b0) !reset_n_i |=>
      (!sys_tick_o && !clkout_pin_oe_o && main_osc_en_o && low_osc_en_o))
      else $error("reset state wrong");
   pin_enable_a: assert property (1'b1 |=>
      clkout_pin_oe_o == $past(port_pin_dir_bit_i && port_pin_alt_fn_bit_i))
      else $error("clock pin enable wrong");
   unmapped_read_a: assert property (rd_i && addr_i > MULT_SELECT_REG_OFS |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   read_hold_a: assert property (!rd_i |=> $stable(rdata_o))
      else $error("read data moved without a read");
   mult_reg_a: assert property (rd_i && addr_i == MULT_SELECT_REG_OFS |=>
      rdata_o[31:1] == 31'h0) else $error("multiplier register upper bits set");
   core_pair_a: assert property (core_bus_tick_o == core_free_tick_o)
      else $error("core clocks differ");
   idle_stop_a: assert property (lp_enter_i && lp_mode_i == LP_IDLE |=>
      ##2 (!core_bus_tick_o) [*8]) else $error("core clock runs in idle");
   tick_ref_gap_a: assert property (tick_ref_tick_o |=> (!tick_ref_tick_o) [*8])
      else $error("tick reference too fast");
   warm_start_a: assert property (wr_i && addr_i == OSC_CONTROL_REG_OFS &&
      wdata_i[WARMUP_START_BIT] && wdata_i[WARMUP_TIME_LSB +: 3] != 3'h0 |=>
      ##[0:2] warmup_running_flag_o)
      else $error("warm-up flag did not rise");

   cover property (wr_i && addr_i == OSC_CONTROL_REG_OFS && wdata_i[0]);
   cover property (lp_enter_i && lp_mode_i == LP_IDLE);
   cover property ($rose(clkout_pin_oe_o));
endmodule : ckg_clock_ctrl_chk

bind ckg_clock_ctrl ckg_clock_ctrl_chk u_chk (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
   .rd_i, .rdata_o, .lp_enter_i, .lp_mode_i, .port_pin_dir_bit_i, .port_pin_alt_fn_bit_i,
   .sys_tick_o, .core_bus_tick_o, .core_free_tick_o, .tick_ref_tick_o,
   .warmup_running_flag_o, .clkout_pin_oe_o, .main_osc_en_o, .low_osc_en_o);
`default_nettype wire

//--- sim/ckg_clock_ctrl_tb.sv
`default_nettype none
module ckg_clock_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ckg_pkg::*;
   logic clk, reset_n, main_osc, low_osc, main_en, low_en, wr, rd, lp_enter, wake, dir, alt;
   logic hs, sys, pre, cbt, cft, tr, wf, pin, oe, pin_q;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [1:0] lp_mode;
   int n_fail, check_count, n, k;
   int cnt[8];

   ckg_osc_model u_osc (.main_en_i(main_en), .low_en_i(low_en), .main_osc_o(main_osc),
      .low_osc_o(low_osc));
   ckg_clock_ctrl u_dut (.clk_i(clk), .reset_n_i(reset_n), .main_osc_i(main_osc),
      .low_osc_i(low_osc), .main_osc_en_o(main_en), .low_osc_en_o(low_en), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .lp_enter_i(lp_enter),
      .lp_mode_i(lp_mode), .wake_i(wake), .port_pin_dir_bit_i(dir),
      .port_pin_alt_fn_bit_i(alt), .high_speed_tick_o(hs), .sys_tick_o(sys),
      .prescaler_tick_o(pre), .core_bus_tick_o(cbt), .core_free_tick_o(cft),
      .tick_ref_tick_o(tr), .warmup_running_flag_o(wf), .clkout_pin_o(pin),
      .clkout_pin_oe_o(oe));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // tick counters; pin activity counts edges since the pin runs at half the tick rate
   always @(posedge clk) begin
      cnt[0] += hs;
      cnt[1] += sys;
      cnt[2] += pre;
      cnt[3] += cbt;
      cnt[4] += tr;
      cnt[5] += (pin !== pin_q);
      pin_q <= pin;
   end
   always @(posedge main_osc) cnt[6]++;
   always @(posedge low_osc) cnt[7]++;

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // async oscillators make counts jitter by a tick or two
   task near(input string nm, input int seen, input int exp, input int tol);
      check(nm, (seen >= exp - tol && seen <= exp + tol) ? exp : seen, exp);
   endtask : near
   task wr_reg(input logic [7:0] a, input logic [31:0] dt);
      @(posedge clk);
      addr <= a;
      wdata <= dt;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task rd_reg(input logic [7:0] a, output logic [31:0] dt);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 dt = rdata;
   endtask : rd_reg
   task pulse(input logic is_wake, input logic [1:0] m);
      @(posedge clk);
      lp_mode <= m;
      lp_enter <= !is_wake;
      wake <= is_wake;
      @(posedge clk);
      lp_enter <= 1'b0;
      wake <= 1'b0;
   endtask : pulse
   task meas(input int w);
      @(posedge clk);
      #1 cnt = '{default: 0};
      repeat (w) @(posedge clk);
      #1;
   endtask : meas
   task warm_len(input logic [31:0] cmd, output int len);
      wr_reg(OSC_CONTROL_REG_OFS, cmd);
      rd_reg(OSC_CONTROL_REG_OFS, d);
      check("warm flag", {31'h0, d[1]}, 32'h1);
      len = 0;
      while (wf !== 1'b0 && len < 20000) begin
         @(posedge clk);
         len++;
      end
   endtask : warm_len
   task report_and_stop;
      $display("checks %0d errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   initial begin
      #600_000;
      n_fail++;
      report_and_stop;
   end

   initial begin
      {reset_n, wr, rd, lp_enter, wake, dir, alt} = '0;
      {addr, wdata, lp_mode} = '0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rd_reg(OSC_CONTROL_REG_OFS, d);
      check("osc reg", d & 32'h703, 32'h600);
      rd_reg(SYS_CLOCK_CFG_REG_OFS, d);
      check("cfg reg", d & 32'h177, 32'h0);
      rd_reg(SYSCLK_SELECT_REG_OFS, d);
      check("sel reg", d, 32'h0);
      rd_reg(MULT_SELECT_REG_OFS, d);
      check("mult reg", d, 32'h0);
      rd_reg(8'h10, d);
      check("unmapped", d, 32'h0);
      meas(1024);
      near("hs at reset", cnt[0], cnt[6], 2);
      near("sys at reset", cnt[1], cnt[6], 2);
      near("pre at reset", cnt[2], cnt[6], 2);
      near("tick ref", cnt[4], cnt[6] / 32, 1);
      for (k = 0; k < 4; k++) begin
         wr_reg(SYS_CLOCK_CFG_REG_OFS, 32'(k));
         meas(1024);
         near("gear", cnt[1], cnt[0] >> k, 2);
      end
      wr_reg(SYS_CLOCK_CFG_REG_OFS, 32'h5);
      rd_reg(SYS_CLOCK_CFG_REG_OFS, d);
      check("reserved gear", d & 32'h7, 32'h3);
      for (k = 0; k < 6; k++) begin
         wr_reg(SYS_CLOCK_CFG_REG_OFS, 32'((k << 4) | ((k != 0) << 8) | 1));
         meas(1024);
         near("prescaler", cnt[2], (k != 0) ? cnt[0] >> k : cnt[1], 2);
      end
      @(posedge clk);
      dir <= 1'b1;
      alt <= 1'b1;
      for (k = 0; k < 4; k++) begin
         wr_reg(SYS_CLOCK_CFG_REG_OFS, 32'(k << 12));
         meas(1024);
         n = (k == 0) ? cnt[7] : (k == 1) ? cnt[1] / 2 : (k == 2) ? cnt[1] : cnt[2];
         near("clock pin", cnt[5], n, 2);
      end
      wr_reg(OSC_CONTROL_REG_OFS, 32'h700);
      wr_reg(MULT_SELECT_REG_OFS, 32'h1);
      repeat (64) @(posedge clk);
      meas(1024);
      near("multiplied", cnt[0], 4 * cnt[6], 6);
      wr_reg(MULT_SELECT_REG_OFS, 32'h0);
      warm_len(32'h611, n);
      near("warm main", n, 1024 * 8, 40);
      warm_len(32'h615, n);
      near("warm low", n, 64 * 20, 40);
      // software switches only after warm-up has completed
      wr_reg(SYSCLK_SELECT_REG_OFS, 32'h2);
      repeat (100) @(posedge clk);
      rd_reg(SYSCLK_SELECT_REG_OFS, d);
      check("to low", d, 32'h3);
      meas(1024);
      near("sys low", cnt[1], cnt[7], 2);
      wr_reg(SYSCLK_SELECT_REG_OFS, 32'h0);
      repeat (100) @(posedge clk);
      rd_reg(SYSCLK_SELECT_REG_OFS, d);
      check("to high", d, 32'h0);
      pulse(1'b0, LP_IDLE);
      meas(256);
      check("idle core", 32'(cnt[3]), 32'h0);
      pulse(1'b1, 2'h0);
      // sleep wakes through the low-speed warm-up still programmed
      pulse(1'b0, LP_SLEEP);
      meas(64);
      check("sleep core", 32'(cnt[3]), 32'h0);
      pulse(1'b1, 2'h0);
      repeat (1400) @(posedge clk);
      wr_reg(OSC_CONTROL_REG_OFS, 32'h610);
      pulse(1'b0, LP_STOP);
      repeat (50) @(posedge clk);
      pulse(1'b1, 2'h0);
      repeat (4) @(posedge clk);
      check("wake warm", {31'h0, wf}, 32'h1);
      meas(4000);
      check("core held", 32'(cnt[3]), 32'h0);
      n = 0;
      while (wf !== 1'b0 && n < 10000) begin
         @(posedge clk);
         n++;
      end
      meas(1024);
      near("core runs", cnt[3], cnt[6], 2);
      report_and_stop;
   end
endmodule : ckg_clock_ctrl_tb
`default_nettype wire

//--- sim/ckg_osc_model.sv
`default_nettype none
module ckg_osc_model (
   // oscillator enables from the block
   input wire logic main_en_i,
   input wire logic low_en_i,
   // oscillator waveforms
   output logic main_osc_o,
   output logic low_osc_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // a disabled oscillator parks low instead of holding its last phase
   initial begin
      main_osc_o = 1'b0;
      forever #32 main_osc_o = main_en_i ? ~main_osc_o : 1'b0;
   end
   initial begin
      low_osc_o = 1'b0;
      forever #80 low_osc_o = low_en_i ? ~low_osc_o : 1'b0;
   end
endmodule : ckg_osc_model
`default_nettype wire
